// ---- verilog/synth_cfg_regs.svh ----
`ifndef SYNTH_CFG_REGS_SVH
`define SYNTH_CFG_REGS_SVH
// register select codes in the low nibble of each serial word
`define SEL_MSB 3
`define SEL_LSB 0
`define CODE_R0 4'h0
`define CODE_R4 4'h4
`define CODE_RF_OUT 4'h6
`define CODE_LOCK 4'h7
`define CODE_FIXED 4'h8
`define CODE_CAL 4'h9
`define R4_DBUF_BIT 14
////////////////////////////////////////////////////////////////////////////////
`define RF_GATED_BIT 30
`define RF_NEG_BIT 29
`define RF_FB_BIT 24
`define RF_DIV_MSB 23
`define RF_DIV_LSB 21
`define RF_BLEED_MSB 20
`define RF_BLEED_LSB 13
`define RF_MUTE_BIT 11
`define RF_AUX_DIS_BIT 10
`define RF_MAIN_EN_BIT 6
`define RF_PWR_MSB 5
`define RF_PWR_LSB 4
////////////////////////////////////////////////////////////////////////////////
`define LK_SYNC_BIT 25
`define LK_CNT_MSB 9
`define LK_CNT_LSB 8
`define LK_LOL_BIT 7
`define LK_PREC_MSB 6
`define LK_PREC_LSB 5
`define LK_MODE_BIT 4
////////////////////////////////////////////////////////////////////////////////
`define CAL_BAND_MSB 31
`define CAL_BAND_LSB 24
`define CAL_TMO_MSB 23
`define CAL_TMO_LSB 14
`define CAL_ALC_MSB 13
`define CAL_ALC_LSB 9
`define CAL_SET_MSB 8
`define CAL_SET_LSB 4
////////////////////////////////////////////////////////////////////////////////
`define RF_OUT_RST 32'h0000_0406
`define LK_RST 32'h1000_0007
`define FIXED_RST 32'h0000_0008
`define CAL_RST 32'h0000_0009
`define FIXED_WORD 32'h102d0428
// lock windows in picoseconds
`define WIN_5NS_PS 14'h1388
`define WIN_6NS_PS 14'h1770
`define WIN_8NS_PS 14'h1f40
`define WIN_12NS_PS 14'h2ee0
`define WIN_FIXED_PS 14'h0b54
// pin indices in the synchroniser bank
`define PIN_LE 0
`define PIN_LOCK 1
`define PIN_REF 2
`define PIN_PD 3
`define PIN_N 4
`endif

// ---- verilog/synth_cfg_pkg.sv ----
package synth_cfg_pkg;
	typedef logic [31:0] cfg_word_t;
	typedef enum logic [1:0] {
		LD_IDLE = 2'h0,
		LD_WAIT = 2'h1,
		LD_FIRE = 2'h3
	} load_state_t;
endpackage

// ---- verilog/serial_word_if.sv ----
`timescale 1ns/1ps
interface serial_word_if #(parameter int WORD_W = 32);
	logic [WORD_W-1:0] word;
	modport producer (output word);
	modport consumer (input word);
endinterface

// ---- verilog/serial_word_shifter.sv ----
`timescale 1ns/1ps
module serial_word_shifter #(
	parameter int WORD_W = 32
) (
	input wire logic link_clk,
	input wire logic rst_n,
	input wire logic serial_data,
	serial_word_if.producer sw
);
	logic [WORD_W-1:0] shift_r;

	////////////////////////////////////////////////////////////////////////////////
	// msb first; the last bit shifted lands in bit 0 with the select field
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_r <= '0;
		end else begin
			shift_r <= {shift_r[WORD_W-2:0], serial_data};
		end
	end

	assign sw.word = shift_r;

	a_shift_in: assert property (@(posedge link_clk) disable iff (!rst_n)
		##1 shift_r[0] == $past(serial_data))
		else $error("serial bit not shifted into word");
endmodule

// ---- verilog/synth_output_lock_config_regs.sv ----
`timescale 1ns/1ps
`include "synth_cfg_regs.svh"
module synth_output_lock_config_regs #(
	parameter int WORD_W = 32,
	parameter int SYNC_N = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic serial_data,
	input wire logic latch_strobe,
	input wire logic lock_in,
	input wire logic ref_in,
	input wire logic power_down,
	output logic neg_bleed_on,
	output logic [7:0] bleed_level,
	output logic feedback_direct,
	output logic [2:0] divider_select,
	output logic [6:0] divider_ratio,
	output logic main_output_on,
	output logic aux_output_on,
	output logic [1:0] main_output_power,
	output logic divider_load,
	output logic [1:0] lock_count,
	output logic reference_loss_mode,
	output logic [13:0] lock_window_ps,
	output logic [7:0] band_division,
	output logic [9:0] band_select_timeout,
	output logic [4:0] level_cal_wait,
	output logic [4:0] settle_timeout,
	output logic fixed_word_ok
);
	if (WORD_W != 32 || SYNC_N != 3) begin : g_check
		$error("only 32 bit words and three stage synchronisers are supported");
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	logic rst_q1_r;
	logic rst_q2_r;
	logic rst_s_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q1_r <= 1'b0;
			rst_q2_r <= 1'b0;
		end else begin
			rst_q1_r <= 1'b1;
			rst_q2_r <= rst_q1_r;
		end
	end

	assign rst_s_n = rst_q2_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_s_n);

	////////////////////////////////////////////////////////////////////////////////
	// serial shifter on the link clock
	serial_word_if #(.WORD_W(WORD_W)) sw ();

	serial_word_shifter #(.WORD_W(WORD_W)) u_shift (
		.link_clk(link_clk),
		.rst_n(rst_s_n),
		.serial_data(serial_data),
		.sw(sw.producer)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: a level changes once stages two and three agree
	logic [`PIN_N-1:0] pin_in;
	logic [`PIN_N-1:0] s1_r;
	logic [`PIN_N-1:0] s2_r;
	logic [`PIN_N-1:0] s3_r;
	logic [`PIN_N-1:0] lvl_r;
	logic [`PIN_N-1:0] lvl_d_r;
	logic [`PIN_N-1:0] rise;

	assign pin_in = {power_down, ref_in, lock_in, latch_strobe};

	for (genvar i = 0; i < `PIN_N; i++) begin : g_sync
		always_ff @(posedge clk or negedge rst_s_n) begin
			if (!rst_s_n) begin
				s1_r[i] <= 1'b0;
				s2_r[i] <= 1'b0;
				s3_r[i] <= 1'b0;
				lvl_r[i] <= 1'b0;
				lvl_d_r[i] <= 1'b0;
			end else begin
				s1_r[i] <= pin_in[i];
				s2_r[i] <= s1_r[i];
				s3_r[i] <= s2_r[i];
				if (s2_r[i] == s3_r[i]) begin
					lvl_r[i] <= s3_r[i];
				end
				lvl_d_r[i] <= lvl_r[i];
			end
		end
		assign rise[i] = lvl_r[i] & ~lvl_d_r[i];
	end

	logic le_rise;
	logic locked;
	logic ref_rise;
	logic pd;
	logic [3:0] sel;

	assign le_rise = rise[`PIN_LE];
	assign locked = lvl_r[`PIN_LOCK];
	assign ref_rise = rise[`PIN_REF];
	assign pd = lvl_r[`PIN_PD];
	// the link clock is idle while the strobe is high, so the word is steady here
	assign sel = sw.word[`SEL_MSB:`SEL_LSB];

	////////////////////////////////////////////////////////////////////////////////
	// register bank; power down does not gate loading
	synth_cfg_pkg::cfg_word_t rf_out_r;
	synth_cfg_pkg::cfg_word_t lock_cfg_r;
	synth_cfg_pkg::cfg_word_t fixed_r;
	synth_cfg_pkg::cfg_word_t cal_r;
	logic dbuf_en_r;
	logic r0_write;

	assign r0_write = le_rise && sel == `CODE_R0;

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			rf_out_r <= `RF_OUT_RST;
			lock_cfg_r <= `LK_RST;
			fixed_r <= `FIXED_RST;
			cal_r <= `CAL_RST;
			dbuf_en_r <= 1'b0;
		end else if (le_rise) begin
			case (sel)
				`CODE_RF_OUT: rf_out_r <= sw.word;
				`CODE_LOCK: lock_cfg_r <= sw.word;
				`CODE_FIXED: fixed_r <= sw.word;
				`CODE_CAL: cal_r <= sw.word;
				`CODE_R4: dbuf_en_r <= sw.word[`R4_DBUF_BIT];
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// divider select double buffer
	logic [2:0] div_shadow_r;
	logic [2:0] div_active_r;

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			div_shadow_r <= 3'h0;
			div_active_r <= 3'h0;
		end else if (le_rise && sel == `CODE_RF_OUT) begin
			div_shadow_r <= sw.word[`RF_DIV_MSB:`RF_DIV_LSB];
			if (!dbuf_en_r) begin
				div_active_r <= sw.word[`RF_DIV_MSB:`RF_DIV_LSB];
			end
		end else if (r0_write && dbuf_en_r) begin
			div_active_r <= div_shadow_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// divider load, optionally held for the next reference rising edge
	synth_cfg_pkg::load_state_t ld_st_r;

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ld_st_r <= synth_cfg_pkg::LD_IDLE;
		end else begin
			case (ld_st_r)
				synth_cfg_pkg::LD_IDLE: begin
					if (r0_write && lock_cfg_r[`LK_SYNC_BIT]) begin
						ld_st_r <= synth_cfg_pkg::LD_WAIT;
					end else if (r0_write) begin
						ld_st_r <= synth_cfg_pkg::LD_FIRE;
					end
				end
				synth_cfg_pkg::LD_WAIT: begin
					if (ref_rise) begin
						ld_st_r <= synth_cfg_pkg::LD_FIRE;
					end
				end
				synth_cfg_pkg::LD_FIRE: ld_st_r <= synth_cfg_pkg::LD_IDLE;
				default: ld_st_r <= synth_cfg_pkg::LD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			divider_load <= 1'b0;
		end else begin
			divider_load <= (ld_st_r == synth_cfg_pkg::LD_FIRE);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output routing, bleed and enables
	logic lock_ok_gate;
	logic [6:0] ratio_nxt;

	// with the mute bit set, a lock that has not arrived keeps the stage muted; power down wins over all
	assign lock_ok_gate = !rf_out_r[`RF_MUTE_BIT] || locked;
	// codes above 6 are not defined; clamp to the largest ratio
	assign ratio_nxt = (div_active_r > 3'h6) ? 7'h40 : 7'(7'h01 << div_active_r);

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			neg_bleed_on <= 1'b0;
			bleed_level <= 8'h00;
			main_output_on <= 1'b0;
			aux_output_on <= 1'b0;
			main_output_power <= 2'h0;
		end else begin
			neg_bleed_on <= rf_out_r[`RF_NEG_BIT] && !pd
				&& !(rf_out_r[`RF_GATED_BIT] && !locked);
			bleed_level <= rf_out_r[`RF_BLEED_MSB:`RF_BLEED_LSB];
			main_output_on <= rf_out_r[`RF_MAIN_EN_BIT] && lock_ok_gate && !pd;
			aux_output_on <= !rf_out_r[`RF_AUX_DIS_BIT] && lock_ok_gate && !pd;
			main_output_power <= rf_out_r[`RF_PWR_MSB:`RF_PWR_LSB];
		end
	end

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			feedback_direct <= 1'b0;
			divider_select <= 3'h0;
			divider_ratio <= 7'h01;
		end else begin
			feedback_direct <= rf_out_r[`RF_FB_BIT];
			divider_select <= div_active_r;
			divider_ratio <= ratio_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// lock detector settings
	logic [13:0] win_nxt;

	always_comb begin
		win_nxt = `WIN_FIXED_PS;
		if (!lock_cfg_r[`LK_MODE_BIT]) begin
			case (lock_cfg_r[`LK_PREC_MSB:`LK_PREC_LSB])
				2'h0: win_nxt = `WIN_5NS_PS;
				2'h1: win_nxt = `WIN_6NS_PS;
				2'h2: win_nxt = `WIN_8NS_PS;
				default: win_nxt = `WIN_12NS_PS;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			lock_count <= 2'h0;
			reference_loss_mode <= 1'b0;
			lock_window_ps <= `WIN_5NS_PS;
		end else begin
			lock_count <= lock_cfg_r[`LK_CNT_MSB:`LK_CNT_LSB];
			reference_loss_mode <= lock_cfg_r[`LK_LOL_BIT];
			lock_window_ps <= win_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// calibration timing and the fixed word check
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			band_division <= 8'h00;
			band_select_timeout <= 10'h000;
			level_cal_wait <= 5'h00;
			settle_timeout <= 5'h00;
			fixed_word_ok <= 1'b0;
		end else begin
			band_division <= cal_r[`CAL_BAND_MSB:`CAL_BAND_LSB];
			band_select_timeout <= cal_r[`CAL_TMO_MSB:`CAL_TMO_LSB];
			level_cal_wait <= cal_r[`CAL_ALC_MSB:`CAL_ALC_LSB];
			settle_timeout <= cal_r[`CAL_SET_MSB:`CAL_SET_LSB];
			fixed_word_ok <= (fixed_r == `FIXED_WORD);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_wait_ref;
		ld_st_r == synth_cfg_pkg::LD_WAIT && !ref_rise;
	endsequence

	sequence s_ref_edge;
		ld_st_r == synth_cfg_pkg::LD_WAIT && ref_rise;
	endsequence

	a_rf_write_store: assert property (le_rise && sel == `CODE_RF_OUT
		|=> rf_out_r == $past(sw.word))
		else $error("output configuration word not stored");

	a_lock_write_store: assert property (le_rise && sel == `CODE_LOCK
		|=> lock_cfg_r == $past(sw.word))
		else $error("lock detect word not stored");

	a_gated_bleed_off: assert property (rf_out_r[`RF_GATED_BIT] && !locked
		|=> !neg_bleed_on)
		else $error("bleed on before lock");

	a_neg_bleed_on: assert property (rf_out_r[`RF_NEG_BIT] && !rf_out_r[`RF_GATED_BIT]
		&& !pd |=> neg_bleed_on)
		else $error("negative bleed not enabled");

	a_feedback_route: assert property (##1 feedback_direct == $past(rf_out_r[`RF_FB_BIT]))
		else $error("feedback route mismatch");

	a_mute_lock: assert property (rf_out_r[`RF_MUTE_BIT] && !locked
		|=> !main_output_on && !aux_output_on)
		else $error("output on before lock while muted");

	a_aux_disable: assert property (rf_out_r[`RF_AUX_DIS_BIT] |=> !aux_output_on)
		else $error("aux output on while disabled");

	a_main_enable: assert property (!rf_out_r[`RF_MAIN_EN_BIT] |=> !main_output_on)
		else $error("main output on while disabled");

	a_div_buffered: assert property (le_rise && sel == `CODE_RF_OUT && dbuf_en_r
		|=> $stable(div_active_r))
		else $error("buffered divider changed without register zero");

	a_le_sync_wait: assert property (s_wait_ref |=> ##1 !divider_load)
		else $error("divider load before reference edge");

	a_le_sync_fire: assert property (s_ref_edge |=> ##1 divider_load)
		else $error("divider load missing after reference edge");

	a_window_fixed: assert property (lock_cfg_r[`LK_MODE_BIT]
		|=> lock_window_ps == `WIN_FIXED_PS)
		else $error("fixed lock window not selected");

	a_lock_count: assert property (##1 lock_count == $past(lock_cfg_r[`LK_CNT_MSB:`LK_CNT_LSB]))
		else $error("lock count mismatch");

	a_cal_timeout: assert property (le_rise && sel == `CODE_CAL
		|=> ##1 band_select_timeout == $past(sw.word[`CAL_TMO_MSB:`CAL_TMO_LSB], 2))
		else $error("band select timeout not applied");
endmodule

// ---- test/host_serial_model.sv ----
`timescale 1ns/1ps
// host side of the three-wire port: link clock runs only inside a word
module host_serial_model #(
	parameter bit INTEGER_MODE = 1'b0
) (
	input wire logic clk,
	output logic link_clk,
	output logic serial_data,
	output logic latch_strobe
);
	logic bleed_used;
	initial begin
		link_clk = 1'b0;
		serial_data = 1'b0;
		latch_strobe = 1'b0;
		bleed_used = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// raw skips the reserved-bit fixes so a scenario can send a broken word
	task automatic send(input synth_cfg_pkg::cfg_word_t w, input bit raw,
		output synth_cfg_pkg::cfg_word_t s);
		s = w;
		if (!raw) begin
			case (w[3:0])
			4'h6: begin
				s = (w & ~32'h9e00_1380) | 32'h1400_0000;
				if (INTEGER_MODE) s[29] = 1'b0;
				bleed_used = s[29];
			end
			4'h7: begin
				s = (w & 32'h0200_03ff) | 32'h1000_0000;
				if (bleed_used) s[6:5] = 2'h3;
			end
			4'h8: s = 32'h102d_0428;
			default: ;
			endcase
		end
		#7;
		for (int i = 31; i >= 0; i--) begin
			serial_data = s[i];
			#40 link_clk = 1'b1;
			#40 link_clk = 1'b0;
		end
		// idle data shows the inverse so a stale sample never looks right
		serial_data = ~s[0];
		@(negedge clk);
		latch_strobe = 1'b1;
		repeat (6) @(negedge clk);
		latch_strobe = 1'b0;
		repeat (4) @(negedge clk);
	endtask
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
	logic clk, rst_n, link_clk, serial_data, latch_strobe, lock_in, ref_in, power_down;
	logic neg_bleed_on, feedback_direct, main_output_on, aux_output_on, divider_load;
	logic reference_loss_mode, fixed_word_ok;
	logic [7:0] bleed_level, band_division, loads_exp, loads_seen;
	logic [2:0] divider_select, act_div;
	logic [6:0] divider_ratio;
	logic [1:0] main_output_power, lock_count;
	logic [13:0] lock_window_ps;
	logic [9:0] band_select_timeout;
	logic [4:0] level_cal_wait, settle_timeout;
	synth_cfg_pkg::cfg_word_t rf_w, lk_w, fx_w, cal_w, r, s;
	logic dbuf, ref_run;
	logic [31:0] seed;
	logic [77:0] exp_q[$];
	int err_total, n_compared, cyc, rc;
	event chk;
	host_serial_model u_host (.clk, .link_clk, .serial_data, .latch_strobe);
	synth_output_lock_config_regs u_synth_output_lock_config_regs (.clk, .rst_n, .link_clk,
		.serial_data, .latch_strobe, .lock_in, .ref_in, .power_down, .neg_bleed_on, .bleed_level,
		.feedback_direct, .divider_select, .divider_ratio, .main_output_on, .aux_output_on,
		.main_output_power, .divider_load, .lock_count, .reference_loss_mode, .lock_window_ps,
		.band_division, .band_select_timeout, .level_cal_wait, .settle_timeout, .fixed_word_ok);
	initial clk = 1'b0;
	always #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [77:0] exp_out();
		logic g;
		logic [13:0] win;
		g = !power_down && (!rf_w[11] || lock_in);
		case (lk_w[6:5])
		2'h0: win = 14'h1388;
		2'h1: win = 14'h1770;
		2'h2: win = 14'h1f40;
		default: win = 14'h2ee0;
		endcase
		if (lk_w[4]) win = 14'h0b54;
		return {rf_w[29] && !power_down && (!rf_w[30] || lock_in), rf_w[20:13], rf_w[24],
			act_div, (act_div == 3'h7) ? 7'h40 : 7'h01 << act_div, rf_w[6] && g, !rf_w[10] && g,
			rf_w[5:4], lk_w[9:8], lk_w[7], win, cal_w[31:24], cal_w[23:14], cal_w[13:9],
			cal_w[8:4], fx_w == 32'h102d_0428, loads_exp};
	endfunction
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmp(input logic [77:0] e, input logic [77:0] g);
		n_compared++;
		if (e !== g) begin
			err_total++;
			$display("[FAIL] %0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic check();
		exp_q.push_back(exp_out());
		->chk;
	endtask
	// 30 cycles covers strobe sync plus one slow reference period for the load pulse
	task automatic wr(input synth_cfg_pkg::cfg_word_t w, input bit raw);
		u_host.send(w, raw, s);
		case (s[3:0])
		4'h0: begin
			act_div = rf_w[23:21];
			loads_exp++;
		end
		// clearing the buffer bit moves nothing: a pending shadow waits for register zero
		4'h4: dbuf = s[14];
		4'h6: begin
			rf_w = s;
			if (!dbuf) act_div = s[23:21];
		end
		4'h7: lk_w = s;
		4'h8: fx_w = s;
		4'h9: cal_w = s;
		default: ;
		endcase
		repeat (30) @(negedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always begin
		@(chk);
		cmp(exp_q.pop_front(), {neg_bleed_on, bleed_level, feedback_direct, divider_select,
			divider_ratio, main_output_on, aux_output_on, main_output_power, lock_count,
			reference_loss_mode, lock_window_ps, band_division, band_select_timeout,
			level_cal_wait, settle_timeout, fixed_word_ok, loads_seen});
	end
	always @(posedge clk) begin
		cyc++;
		if (divider_load === 1'b1) loads_seen++;
		if (cyc == 40000) begin
			err_total++;
			report_and_stop();
		end
	end
	always @(negedge clk) begin
		if (ref_run) begin
			rc++;
			if (rc == 5) begin
				rc = 0;
				ref_in = ~ref_in;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		lock_in = 1'b0;
		ref_in = 1'b0;
		power_down = 1'b0;
		ref_run = 1'b1;
		{rc, cyc, err_total, n_compared} = '0;
		{loads_exp, loads_seen, dbuf, act_div} = '0;
		seed = 32'h0000_b90f;
		rf_w = 32'h0000_0406;
		lk_w = 32'h1000_0007;
		fx_w = 32'h0000_0008;
		cal_w = 32'h0000_0009;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (5) @(negedge clk);
		check();
		for (int i = 0; i < 8; i++) begin
			r = xs();
			wr({r[31:7], i[1:0], i[2], 4'h7}, 1'b0);
			check();
		end
		repeat (3) begin
			r = xs();
			wr({r[31:4], 4'h9}, 1'b0);
			check();
		end
		wr(32'h0000_0008, 1'b0);
		check();
		r = xs();
		wr({r[31:4], 4'h8}, 1'b1);
		check();
		wr(32'h6000_0846, 1'b0);
		for (int i = 0; i < 4; i++) begin
			lock_in = i[0];
			power_down = i[1];
			repeat (12) @(negedge clk);
			check();
		end
		repeat (6) begin
			r = xs();
			lock_in = r[1];
			power_down = r[2] & r[3];
			wr({r[31:4], 4'h6}, 1'b0);
			check();
		end
		for (int c = 5; c < 16; c += 5) begin
			r = xs();
			wr({r[31:4], c[3:0]}, 1'b1);
			check();
		end
		power_down = 1'b0;
		lock_in = 1'b1;
		wr(32'h0000_4004, 1'b0);
		r = xs();
		wr({r[31:24], act_div + 3'h1, r[20:4], 4'h6}, 1'b0);
		check();
		wr(32'h0000_0000, 1'b0);
		check();
		// with the reference stalled a synced load must not fire
		wr(32'h1200_0007, 1'b0);
		ref_run = 1'b0;
		wr(32'h0000_0000, 1'b0);
		loads_exp--;
		check();
		ref_run = 1'b1;
		loads_exp++;
		repeat (30) @(negedge clk);
		check();
		wr(32'h0000_0004, 1'b0);
		check();
		power_down = 1'b1;
		r = xs();
		wr({r[31:4], 4'h9}, 1'b0);
		check();
		r = xs();
		wr({r[31:4], 4'h6}, 1'b0);
		check();
		report_and_stop();
	end
endmodule
